//--- core/fdm_regs.sv
// fdm_regs: holding register bank, request decoder and link supervision of the fan drive
// ****************************************
// Functional notes
// - out-of-bounds writes rejected, never clamped
// - only functions 03, 04, 06 supported
// - line rate register selects 9.6k or 19.2k
// - framing codes: none/2stop, odd, even
// - nonzero timeout stops fan after seconds
// - station number 1..247, default 1
// - station 0 is broadcast
// - writes while running not saved to storage
// - rate immediate; framing, address after power cycle
// - rate and framing apply only to RS-485
// - service port fixed 57600, framing 0, station 1
// - temporary setpoint write-only, kept while powered
// - writing 1 clears faults, self-returns to 0
// - lower speed limit bounded by default, upper
// - upper speed limit bounded by lower, default
// - carrier 14 kHz slow, 8 kHz fast
// - 64 stored registers, 22 user-writable
// - mode register selects operating mode
// - mode codes 0..3 and 10..12 supported; the bank accepts any code 0..12
// ****************************************
`timescale 1ns/100ps
module fdm_regs
	import fdm_pkg::*;
#(
	parameter int CLK_PER_SEC = SECOND_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic nv_load_valid,
	input wire fdm_nv_t nv_load,
	input wire logic boot_done,
	input wire logic req_valid,
	input wire fdm_req_t req,
	input wire logic motor_running,
	input wire logic [15:0] measured_speed,
	output logic rsp_valid,
	output fdm_rsp_t rsp,
	output logic nv_wr_valid,
	output fdm_nv_t nv_wr,
	output fdm_link_cfg_t rs485_cfg,
	output fdm_link_cfg_t service_cfg,
	output logic rs485_tick,
	output logic service_tick,
	output logic fault_clear,
	output logic fan_stop,
	output logic carrier_low,
	output logic [3:0] operating_mode,
	output logic [15:0] temp_setpoint,
	output logic running
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [HR_COUNT-1:0][15:0] hreg;
		logic [15:0] temp_sp;
		fdm_boot_t boot;
		fdm_link_cfg_t active;
		logic rsp_valid;
		fdm_rsp_t rsp;
		logic nv_wr_valid;
		fdm_nv_t nv_wr;
		logic fault_clear;
		logic [31:0] sec_cnt;
		logic [15:0] loss_secs;
		logic fan_stop;
		logic [15:0] div485;
		logic [15:0] divsvc;
		logic tick485;
		logic ticksvc;
		logic carrier_low;
	} fdm_state_t;

	fdm_state_t st_r;
	fdm_state_t st_nxt;

	// ****************************************
	// register map helpers
	// ****************************************
	function automatic logic [HR_COUNT-1:0][15:0] reg_defaults();
		logic [HR_COUNT-1:0][15:0] d;
		d = '0;
		d[HR_SPEED_LOWER_LIMIT[5:0]] = SPEED_MIN_DEFAULT;
		d[HR_SPEED_UPPER_LIMIT[5:0]] = SPEED_MAX_DEFAULT;
		d[HR_MOTOR_CURRENT_LIMIT[5:0]] = CURRENT_DEFAULT;
		d[HR_SKIP_BAND_LOW[5:0]] = SPEED_CEILING;
		d[HR_SKIP_BAND_HIGH[5:0]] = SPEED_CEILING;
		d[HR_COAST_DOWN_SPEED[5:0]] = SPEED_CEILING;
		d[HR_OUTPUT_POWER_LIMIT[5:0]] = POWER_DEFAULT;
		d[HR_SLAVE_STATION_NUMBER[5:0]] = STATION_DEFAULT;
		d[HR_LINE_RATE_SELECT[5:0]] = RATE_CODE_SLOW;
		return d;
	endfunction

	// power-on image of the bank; the load phase then overlays the stored words
	localparam logic [HR_COUNT-1:0][15:0] HREG_RESET = reg_defaults();

	// user-writable subset of the stored bank plus the temporary setpoint
	function automatic logic writable(input logic [15:0] a);
		logic ok;
		ok = 1'b0;
		if (a == HR_FAULT_CLEAR_RESTART || a == HR_SPEED_LOWER_LIMIT) begin
			ok = 1'b1;
		end else if (a == HR_SPEED_UPPER_LIMIT || a == HR_MOTOR_CURRENT_LIMIT) begin
			ok = 1'b1;
		end else if (a == HR_FIXED_SPEED_SETPOINT || a == HR_LOOP_FEEDBACK_POLARITY) begin
			ok = 1'b1;
		end else if (a >= HR_SKIP_BAND_LOW && a <= HR_OUTPUT_POWER_LIMIT) begin
			ok = 1'b1;
		end else if (a >= HR_SLAVE_STATION_NUMBER && a <= HR_CHAR_FRAMING_SELECT) begin
			ok = 1'b1;
		end else if (a >= HR_LOOP_REFERENCE_FIXED && a <= HR_LINK_LOSS_TIMEOUT) begin
			ok = 1'b1;
		end else if (a == HR_TEMPORARY_SETPOINT) begin
			ok = 1'b1;
		end
		return ok;
	endfunction

	// bound check against the live bank; nothing is ever coerced
	function automatic logic value_ok(input logic [15:0] a, input logic [15:0] v,
		input logic [HR_COUNT-1:0][15:0] r);
		logic ok;
		logic [15:0] lo_spd;
		logic [15:0] hi_spd;
		lo_spd = r[HR_SPEED_LOWER_LIMIT[5:0]];
		hi_spd = r[HR_SPEED_UPPER_LIMIT[5:0]];
		ok = 1'b1;
		if (a == HR_FAULT_CLEAR_RESTART || a == HR_LOOP_FEEDBACK_POLARITY) begin
			ok = (v <= 16'h0001);
		end else if (a == HR_SPEED_LOWER_LIMIT) begin
			ok = (v >= SPEED_MIN_DEFAULT) && (v <= hi_spd);
		end else if (a == HR_SPEED_UPPER_LIMIT) begin
			ok = (v >= lo_spd) && (v <= SPEED_MAX_DEFAULT);
		end else if (a == HR_MOTOR_CURRENT_LIMIT) begin
			ok = (v != 16'h0000) && (v <= CURRENT_DEFAULT);
		end else if (a == HR_FIXED_SPEED_SETPOINT) begin
			ok = (v >= lo_spd) && (v <= hi_spd);
		end else if (a == HR_SKIP_BAND_LOW) begin
			ok = (v <= r[HR_SKIP_BAND_HIGH[5:0]]);
		end else if (a == HR_SKIP_BAND_HIGH) begin
			ok = (v >= r[HR_SKIP_BAND_LOW[5:0]]) && (v <= SPEED_CEILING);
		end else if (a == HR_OPERATING_MODE_SELECT) begin
			ok = (v <= MODE_MAX);
		end else if (a == HR_COAST_DOWN_SPEED || a == HR_SPEED_COMPARE_LEVEL) begin
			ok = (v <= SPEED_CEILING);
		end else if (a == HR_OUTPUT_POWER_LIMIT) begin
			ok = (v <= POWER_DEFAULT);
		end else if (a == HR_SLAVE_STATION_NUMBER) begin
			ok = (v != 16'h0000) && (v <= STATION_MAX);
		end else if (a == HR_DIGITAL_OUTPUT_FUNCTION) begin
			ok = (v <= OUT_FUNC_MAX);
		end else if (a == HR_LINE_RATE_SELECT) begin
			ok = (v == RATE_CODE_SLOW) || (v == RATE_CODE_FAST);
		end else if (a == HR_CHAR_FRAMING_SELECT) begin
			ok = (v <= FRAMING_MAX);
		end else if (a == HR_LOOP_REFERENCE_FIXED) begin
			ok = (v <= LOOP_REF_MAX);
		end else if (a >= HR_LOOP_GAIN_PROPORTIONAL && a <= HR_LOOP_SAMPLE_PERIOD) begin
			ok = (v <= WORD_MAX_POS);
		end else if (a == HR_LINK_LOSS_TIMEOUT) begin
			ok = (v <= WORD_MAX_POS);
		end
		return ok;
	endfunction

	// shared wrap test: an upward rate switch wraps at once instead of overrunning
	function automatic logic div_wrap(input logic [15:0] cnt, input logic [15:0] div);
		return (cnt >= div - 16'h0001);
	endfunction

	// status word of the only input register
	function automatic logic [15:0] status_word(input fdm_state_t s);
		return {10'h000, s.fan_stop, s.carrier_low,
			s.hreg[HR_OPERATING_MODE_SELECT[5:0]][3:0]};
	endfunction

	// ****************************************
	// next-state logic
	// ****************************************
	always_comb begin
		logic [7:0] own_station;
		logic for_us;
		logic bcast;
		logic wr_ok;
		logic [15:0] rate_div;
		own_station = '0;
		for_us = 1'b0;
		bcast = 1'b0;
		wr_ok = 1'b0;
		rate_div = DIV_SLOW;

		st_nxt = st_r;
		st_nxt.rsp_valid = 1'b0;
		st_nxt.nv_wr_valid = 1'b0;
		st_nxt.fault_clear = 1'b0;
		st_nxt.tick485 = 1'b0;
		st_nxt.ticksvc = 1'b0;

		// the restart register only ever reads back as idle
		st_nxt.hreg[HR_FAULT_CLEAR_RESTART[5:0]] = 16'h0000;

		// ****************************************
		// boot phase and request decode
		// ****************************************
		case (st_r.boot)
			BOOT_LOAD: begin
				if (nv_load_valid) begin
					st_nxt.hreg[nv_load.addr] = nv_load.data;
				end
				// framing and station are frozen here until the next power cycle
				if (boot_done) begin
					st_nxt.active.station = st_r.hreg[HR_SLAVE_STATION_NUMBER[5:0]][7:0];
					st_nxt.active.framing =
						fdm_framing_t'(st_r.hreg[HR_CHAR_FRAMING_SELECT[5:0]][1:0]);
					st_nxt.boot = BOOT_RUN;
				end
			end

			BOOT_RUN: begin
				// the service port answers to its fixed station whatever register 45 holds
				own_station = req.service_port ? SERVICE_STATION : st_r.active.station;
				bcast = (req.station == BROADCAST_STATION);
				for_us = req_valid && (bcast || req.station == own_station);
				if (for_us) begin
					st_nxt.loss_secs = '0;
					st_nxt.sec_cnt = '0;
					st_nxt.rsp_valid = !bcast;
					st_nxt.rsp.func = req.func;
					st_nxt.rsp.exc = EXC_NONE;
					st_nxt.rsp.data = '0;
					if (req.func == FC_READ_HOLDING) begin
						if (req.addr == HR_TEMPORARY_SETPOINT) begin
							st_nxt.rsp.data = '0;
						end else if (req.addr < 16'(HR_COUNT)) begin
							st_nxt.rsp.data = st_r.hreg[req.addr[5:0]];
						end else begin
							st_nxt.rsp.exc = EXC_BAD_ADDRESS;
						end
					end else if (req.func == FC_READ_INPUT) begin
						if (req.addr == IR_DRIVE_STATUS) begin
							st_nxt.rsp.data = status_word(st_r);
						end else begin
							st_nxt.rsp.exc = EXC_BAD_ADDRESS;
						end
					end else if (req.func == FC_WRITE_SINGLE) begin
						if (!writable(req.addr)) begin
							st_nxt.rsp.exc = EXC_BAD_ADDRESS;
						end else if (!value_ok(req.addr, req.data, st_r.hreg)) begin
							st_nxt.rsp.exc = EXC_BAD_VALUE;
						end else begin
							wr_ok = 1'b1;
							st_nxt.rsp.data = req.data;
						end
					end else begin
						st_nxt.rsp.exc = EXC_BAD_FUNCTION;
					end
				end
				// a broadcast is acted on but never answered, so the last answer stands
				if (for_us && bcast) begin
					st_nxt.rsp = st_r.rsp;
				end

				// ****************************************
				// register update
				// ****************************************
				if (wr_ok) begin
					if (req.addr == HR_TEMPORARY_SETPOINT) begin
						st_nxt.temp_sp = req.data;
					end else if (req.addr == HR_FAULT_CLEAR_RESTART) begin
						st_nxt.fault_clear = req.data[0];
						st_nxt.fan_stop = req.data[0] ? 1'b0 : st_r.fan_stop;
					end else begin
						st_nxt.hreg[req.addr[5:0]] = req.data;
						// live copy changes now; storage only while stopped
						st_nxt.nv_wr_valid = !motor_running;
						st_nxt.nv_wr.addr = req.addr[5:0];
						st_nxt.nv_wr.data = req.data;
					end
				end

				// ****************************************
				// link loss supervision, counted in whole seconds
				// ****************************************
				if (st_r.hreg[HR_LINK_LOSS_TIMEOUT[5:0]] == 16'h0000) begin
					st_nxt.sec_cnt = '0;
					st_nxt.loss_secs = '0;
				end else if (!for_us) begin
					if (st_r.sec_cnt >= 32'(CLK_PER_SEC - 1)) begin
						st_nxt.sec_cnt = '0;
						if (st_r.loss_secs != 16'hFFFF) begin
							st_nxt.loss_secs = st_r.loss_secs + 16'h0001;
						end
					end else begin
						st_nxt.sec_cnt = st_r.sec_cnt + 32'h0000_0001;
					end
					if (st_r.loss_secs >= st_r.hreg[HR_LINK_LOSS_TIMEOUT[5:0]]) begin
						st_nxt.fan_stop = 1'b1;
					end
				end
			end

			default: begin
				st_nxt.boot = BOOT_LOAD;
			end
		endcase

		// ****************************************
		// line rate dividers
		// ****************************************
		// rate follows the register at once; service port never looks at it
		if (st_r.hreg[HR_LINE_RATE_SELECT[5:0]] == RATE_CODE_FAST) begin
			rate_div = DIV_FAST;
		end
		if (div_wrap(st_r.div485, rate_div)) begin
			st_nxt.div485 = '0;
			st_nxt.tick485 = 1'b1;
		end else begin
			st_nxt.div485 = st_r.div485 + 16'h0001;
		end
		if (div_wrap(st_r.divsvc, DIV_SERVICE)) begin
			st_nxt.divsvc = '0;
			st_nxt.ticksvc = 1'b1;
		end else begin
			st_nxt.divsvc = st_r.divsvc + 16'h0001;
		end

		// ****************************************
		// carrier selection
		// ****************************************
		// no hysteresis: the pwm stage retimes the change at its own period end
		st_nxt.carrier_low = (measured_speed > {1'b0, st_r.hreg[HR_SPEED_UPPER_LIMIT[5:0]][15:1]});
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= '0;
			st_r.hreg <= HREG_RESET;
			st_r.boot <= BOOT_LOAD;
			st_r.active.station <= SERVICE_STATION;
			st_r.active.framing <= FMT_NONE_2STOP;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign rsp_valid = st_r.rsp_valid;
	assign rsp = st_r.rsp;
	assign nv_wr_valid = st_r.nv_wr_valid;
	assign nv_wr = st_r.nv_wr;
	assign rs485_cfg = st_r.active;
	assign service_cfg = '{framing: FMT_NONE_2STOP, station: SERVICE_STATION};
	assign rs485_tick = st_r.tick485;
	assign service_tick = st_r.ticksvc;
	assign fault_clear = st_r.fault_clear;
	assign fan_stop = st_r.fan_stop;
	assign carrier_low = st_r.carrier_low;
	assign operating_mode = st_r.hreg[HR_OPERATING_MODE_SELECT[5:0]][3:0];
	assign temp_setpoint = st_r.temp_sp;
	assign running = (st_r.boot == BOOT_RUN);

endmodule

//--- pkg/fdm_pkg.sv
// fdm_pkg: constants, register map and request, response and link types of the fan drive register bank
package fdm_pkg;

	// ****************************************
	// clock and line rates
	// ****************************************
	localparam int CLK_HZ = 40_000_000;
	localparam int OVERSAMPLE = 16;
	localparam int RATE_SLOW_BPS = 9600;
	localparam int RATE_FAST_BPS = 19200;
	localparam int SERVICE_BPS = 57600;
	localparam logic [15:0] DIV_SLOW = 16'(CLK_HZ / (RATE_SLOW_BPS * OVERSAMPLE));
	localparam logic [15:0] DIV_FAST = 16'(CLK_HZ / (RATE_FAST_BPS * OVERSAMPLE));
	localparam logic [15:0] DIV_SERVICE = 16'(CLK_HZ / (SERVICE_BPS * OVERSAMPLE));
	localparam int SECOND_CYCLES = CLK_HZ;

	// ****************************************
	// holding register offsets
	// ****************************************
	localparam logic [15:0] HR_FAULT_CLEAR_RESTART = 16'h0000;
	localparam logic [15:0] HR_SPEED_LOWER_LIMIT = 16'h0001;
	localparam logic [15:0] HR_SPEED_UPPER_LIMIT = 16'h0002;
	localparam logic [15:0] HR_MOTOR_CURRENT_LIMIT = 16'h0007;
	localparam logic [15:0] HR_FIXED_SPEED_SETPOINT = 16'h0015;
	localparam logic [15:0] HR_LOOP_FEEDBACK_POLARITY = 16'h001F;
	localparam logic [15:0] HR_SKIP_BAND_LOW = 16'h0020;
	localparam logic [15:0] HR_SKIP_BAND_HIGH = 16'h0021;
	localparam logic [15:0] HR_OPERATING_MODE_SELECT = 16'h0022;
	localparam logic [15:0] HR_COAST_DOWN_SPEED = 16'h0023;
	localparam logic [15:0] HR_OUTPUT_POWER_LIMIT = 16'h0024;
	localparam logic [15:0] HR_SLAVE_STATION_NUMBER = 16'h002D;
	localparam logic [15:0] HR_DIGITAL_OUTPUT_FUNCTION = 16'h002E;
	localparam logic [15:0] HR_LINE_RATE_SELECT = 16'h002F;
	localparam logic [15:0] HR_CHAR_FRAMING_SELECT = 16'h0030;
	localparam logic [15:0] HR_LOOP_REFERENCE_FIXED = 16'h0032;
	localparam logic [15:0] HR_LOOP_GAIN_PROPORTIONAL = 16'h0033;
	localparam logic [15:0] HR_LOOP_GAIN_INTEGRAL = 16'h0034;
	localparam logic [15:0] HR_LOOP_GAIN_DERIVATIVE = 16'h0035;
	localparam logic [15:0] HR_LOOP_SAMPLE_PERIOD = 16'h0036;
	localparam logic [15:0] HR_SPEED_COMPARE_LEVEL = 16'h0037;
	localparam logic [15:0] HR_LINK_LOSS_TIMEOUT = 16'h0038;
	localparam logic [15:0] HR_TEMPORARY_SETPOINT = 16'h0042;
	localparam logic [15:0] IR_DRIVE_STATUS = 16'h0000;
	localparam int HR_COUNT = 64;

	// ****************************************
	// value limits and reset values
	// ****************************************
	localparam logic [15:0] SPEED_MIN_DEFAULT = 16'h012C;
	localparam logic [15:0] SPEED_MAX_DEFAULT = 16'h07D0;
	localparam logic [15:0] CURRENT_DEFAULT = 16'h1964;
	localparam logic [15:0] POWER_DEFAULT = 16'h0A5A;
	localparam logic [15:0] SPEED_CEILING = 16'h4E20;
	localparam logic [15:0] LOOP_REF_MAX = 16'h0064;
	localparam logic [15:0] WORD_MAX_POS = 16'h7FFF;
	localparam logic [15:0] STATION_MAX = 16'h00F7;
	localparam logic [15:0] STATION_DEFAULT = 16'h0001;
	localparam logic [15:0] RATE_CODE_SLOW = 16'h0060;
	localparam logic [15:0] RATE_CODE_FAST = 16'h00C0;
	localparam logic [15:0] MODE_MAX = 16'h000C;
	localparam logic [15:0] OUT_FUNC_MAX = 16'h0003;
	localparam logic [15:0] FRAMING_MAX = 16'h0002;
	localparam logic [7:0] BROADCAST_STATION = 8'h00;
	localparam logic [7:0] SERVICE_STATION = 8'h01;

	// ****************************************
	// function and exception codes
	// ****************************************
	localparam logic [7:0] FC_READ_HOLDING = 8'h03;
	localparam logic [7:0] FC_READ_INPUT = 8'h04;
	localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_BAD_FUNCTION = 8'h01;
	localparam logic [7:0] EXC_BAD_ADDRESS = 8'h02;
	localparam logic [7:0] EXC_BAD_VALUE = 8'h03;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {FMT_NONE_2STOP, FMT_ODD_1STOP, FMT_EVEN_1STOP} fdm_framing_t;
	typedef enum logic {BOOT_LOAD, BOOT_RUN} fdm_boot_t;

	typedef struct packed {
		logic service_port;
		logic [7:0] station;
		logic [7:0] func;
		logic [15:0] addr;
		logic [15:0] data;
	} fdm_req_t;

	typedef struct packed {
		logic [7:0] func;
		logic [7:0] exc;
		logic [15:0] data;
	} fdm_rsp_t;

	typedef struct packed {
		logic [5:0] addr;
		logic [15:0] data;
	} fdm_nv_t;

	typedef struct packed {
		fdm_framing_t framing;
		logic [7:0] station;
	} fdm_link_cfg_t;

endpackage

//--- tb/fdm_regs_sva.sv
// fdm_regs_sva: assertions on the fan drive register bank ports
`timescale 1ns/100ps
module fdm_regs_sva
	import fdm_pkg::*;
#(
	parameter int CLK_PER_SEC = SECOND_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire fdm_req_t req,
	input wire logic motor_running,
	input wire logic rsp_valid,
	input wire fdm_rsp_t rsp,
	input wire logic nv_wr_valid,
	input wire fdm_link_cfg_t rs485_cfg,
	input wire logic service_tick,
	input wire logic fault_clear,
	input wire logic fan_stop,
	input wire logic [15:0] temp_setpoint,
	input wire logic running
);
	logic own;
	logic wr_ok;
	logic bad_fn;
	logic st_bad;
	logic acc;
	// a request is taken only when running and the station matches the port used
	assign own = req_valid && running
		&& req.station == (req.service_port ? SERVICE_STATION : rs485_cfg.station);
	assign wr_ok = own && req.func == FC_WRITE_SINGLE;
	assign bad_fn = own && !(req.func inside {FC_READ_HOLDING, FC_READ_INPUT, FC_WRITE_SINGLE});
	// broadcasts are acted on as well, only never answered
	assign acc = own || (req_valid && running && req.station == BROADCAST_STATION);
	assign st_bad = wr_ok && req.addr == HR_SLAVE_STATION_NUMBER
		&& (req.data > STATION_MAX || req.data == 16'h0000);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// ****
	// properties
	// ****
	a_answer_cause:
		assert property (rsp_valid |-> $past(own)) else $error("answer without request");
	a_bad_func:
		assert property (bad_fn |=> rsp_valid && rsp.exc == EXC_BAD_FUNCTION) else $error("func");
	a_bcast_quiet:
		assert property (req_valid && req.station == BROADCAST_STATION |=> !rsp_valid)
		else $error("broadcast answered");
	a_foreign_quiet:
		assert property (req_valid && !own && req.station != BROADCAST_STATION |=> !rsp_valid)
		else $error("foreign answered");
	a_run_volatile:
		assert property (nv_wr_valid |-> !$past(motor_running) && $past(req_valid))
		else $error("persist while running");
	a_station_range:
		assert property (st_bad |=> rsp.exc == EXC_BAD_VALUE && !nv_wr_valid) else $error("station");
	a_temp_write:
		assert property (wr_ok && req.addr == HR_TEMPORARY_SETPOINT
			|=> temp_setpoint == $past(req.data)) else $error("setpoint");
	a_temp_hidden:
		assert property (own && req.func == FC_READ_HOLDING && req.addr == HR_TEMPORARY_SETPOINT
			|=> rsp.data == 16'h0000) else $error("setpoint readable");
	a_clear_cause:
		assert property (fault_clear |-> $past(acc && req.func == FC_WRITE_SINGLE
			&& req.addr == HR_FAULT_CLEAR_RESTART && req.data == 16'h0001))
			else $error("clear cause");
	a_clear_stop:
		assert property (fault_clear |-> !fan_stop) else $error("stop kept");
	a_cfg_frozen:
		assert property (running && $past(running) |-> $stable(rs485_cfg)) else $error("cfg moved");
	a_svc_spacing:
		assert property (service_tick |=> !service_tick [*8]) else $error("service tick");
	c_persist: cover property (wr_ok ##1 nv_wr_valid);
	c_stop: cover property ($rose(fan_stop));
	c_bcast: cover property (req_valid && req.station == BROADCAST_STATION);
endmodule

bind fdm_regs fdm_regs_sva #(.CLK_PER_SEC(CLK_PER_SEC)) u_sva (.clk(clk), .sys_rst(sys_rst),
	.req_valid(req_valid), .req(req), .motor_running(motor_running), .rsp_valid(rsp_valid),
	.rsp(rsp), .nv_wr_valid(nv_wr_valid), .rs485_cfg(rs485_cfg), .service_tick(service_tick),
	.fault_clear(fault_clear), .fan_stop(fan_stop), .temp_setpoint(temp_setpoint),
	.running(running));

//--- tb/fdm_mstr_model.sv
// fdm_mstr_model: behavioural line master that issues decoded requests
`timescale 1ns/100ps
module fdm_mstr_model
	import fdm_pkg::*;
(
	input wire logic clk,
	output logic req_valid,
	output fdm_req_t req
);
	initial begin
		req_valid = 1'b0;
		req = '0;
	end
	// fields are inverted after release so nothing can lean on a stale request
	task automatic send(input logic svc, input logic [7:0] st, input logic [7:0] fn,
		input logic [15:0] ad, input logic [15:0] dt);
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{service_port: svc, station: st, func: fn, addr: ad, data: dt};
		@(posedge clk);
		req_valid <= 1'b0;
		req <= ~req;
	endtask
endmodule

//--- tb/fdm_regs_test.sv
// fdm_regs_test: self-checking bench for the fan drive register bank
`timescale 1ns/100ps
module fdm_regs_test;
	import fdm_pkg::*;
	localparam int CPS = 10;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic nv_load_valid = 1'b0;
	fdm_nv_t nv_load = '0;
	logic boot_done = 1'b0;
	logic motor_running = 1'b0;
	logic [15:0] measured_speed = 16'h0000;
	logic req_valid, rsp_valid, nv_wr_valid, rs485_tick, service_tick, fault_clear;
	logic fan_stop, carrier_low, running;
	fdm_req_t req;
	fdm_rsp_t rsp;
	fdm_nv_t nv_wr;
	fdm_link_cfg_t rs485_cfg, service_cfg;
	logic [3:0] operating_mode;
	logic [15:0] temp_setpoint, rv;
	logic [32:0] ent;
	logic [32:0] exp_q[$];
	int num_errors = 0;
	int n_tests = 0;
	int seed = 64124;
	int gap;
	logic [31:0] dft[11] = '{32'h0001012C, 32'h000207D0, 32'h00071964, 32'h00204E20,
		32'h00214E20, 32'h00234E20, 32'h00240A5A, 32'h002D0001, 32'h002F0060, 32'h00300002, 0};
	// entries: address, value, expected exception
	logic [39:0] wtab[16] = '{40'h0001012B03, 40'h000107D103, 40'h000207D103, 40'h000107D000,
		40'h000207CF03, 40'h0001012C00, 40'h002D000003, 40'h002D00F803, 40'h002D00F700,
		40'h002F006403, 40'h0030000303, 40'h0038800003, 40'h00387FFF00, 40'h0038000000,
		40'h0003000502, 40'h002E000000};
	logic [3:0] modes[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hA, 4'hB, 4'hC};

	always #12.5 clk = ~clk;

	fdm_mstr_model u_mst (.clk(clk), .req_valid(req_valid), .req(req));
	fdm_regs #(.CLK_PER_SEC(CPS)) u_dut (.clk(clk), .sys_rst(sys_rst),
		.nv_load_valid(nv_load_valid), .nv_load(nv_load), .boot_done(boot_done),
		.req_valid(req_valid), .req(req), .motor_running(motor_running),
		.measured_speed(measured_speed), .rsp_valid(rsp_valid), .rsp(rsp),
		.nv_wr_valid(nv_wr_valid), .nv_wr(nv_wr), .rs485_cfg(rs485_cfg),
		.service_cfg(service_cfg), .rs485_tick(rs485_tick), .service_tick(service_tick),
		.fault_clear(fault_clear),
		.fan_stop(fan_stop), .carrier_low(carrier_low), .operating_mode(operating_mode),
		.temp_setpoint(temp_setpoint), .running(running));

	// ****
	// tasks
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic tx(input logic svc, input logic [7:0] fn, input logic [15:0] ad,
		input logic [15:0] dt, input logic [7:0] ex, input logic [15:0] ed, input logic nv);
		exp_q.push_back({nv, fn, ex, ed});
		u_mst.send(svc, 8'h01, fn, ad, dt);
	endtask
	task automatic wr(input logic [15:0] ad, input logic [15:0] dt, input logic [7:0] ex);
		tx(1'b0, FC_WRITE_SINGLE, ad, dt, ex, dt, ex == EXC_NONE && !motor_running
			&& ad != HR_FAULT_CLEAR_RESTART && ad != HR_TEMPORARY_SETPOINT);
	endtask
	task automatic rd(input logic [15:0] ad, input logic [15:0] ev);
		tx(1'b0, FC_READ_HOLDING, ad, 16'h0000, EXC_NONE, ev, 1'b0);
	endtask
	task automatic tick_gap(ref logic t, output int n);
		n = 0;
		@(negedge clk);
		while (t !== 1'b1) @(negedge clk);
		do begin
			@(negedge clk);
			n++;
		end while (t !== 1'b1 && n < 400);
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// oldest note is matched to each answer as it appears
	always @(negedge clk) begin
		if (rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk(1, 0, "unexpected answer");
			end else begin
				ent = exp_q.pop_front();
				chk(rsp.exc, ent[23:16], "exception");
				if (ent[23:16] == EXC_NONE) chk({rsp.func, rsp.data}, {ent[31:24], ent[15:0]}, "answer");
				chk(nv_wr_valid, ent[32], "persist");
				if (ent[32]) chk(nv_wr.data, ent[15:0], "stored");
			end
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		summarize();
	end

	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		nv_load_valid <= 1'b1;
		nv_load <= '{addr: 6'd48, data: 16'h0002};
		@(posedge clk);
		nv_load_valid <= 1'b0;
		boot_done <= 1'b1;
		repeat (3) @(negedge clk);
		chk(rs485_cfg, {FMT_EVEN_1STOP, SERVICE_STATION}, "boot cfg");
		chk(service_cfg, {FMT_NONE_2STOP, SERVICE_STATION}, "service cfg");
		chk(running, 1, "running");
		foreach (dft[i]) rd(dft[i][31:16], dft[i][15:0]);
		$display("done: defaults");
		foreach (wtab[i]) wr(wtab[i][39:24], wtab[i][23:8], wtab[i][7:0]);
		rd(16'h0001, 16'h012C);
		rd(16'h002D, 16'h00F7);
		@(posedge clk);
		motor_running <= 1'b1;
		@(posedge clk);
		wr(16'h002D, 16'h0007, EXC_NONE);
		motor_running <= 1'b0;
		@(posedge clk);
		rd(16'h002D, 16'h0007);
		for (int f = 0; f < 3; f++) wr(16'h0030, 16'(f), EXC_NONE);
		u_mst.send(1'b0, 8'h07, FC_READ_HOLDING, 16'h0001, 16'h0000);
		u_mst.send(1'b0, BROADCAST_STATION, FC_WRITE_SINGLE, 16'h0015, 16'h01F4);
		rd(16'h0015, 16'h01F4);
		chk(rs485_cfg, {FMT_EVEN_1STOP, SERVICE_STATION}, "cfg held");
		tx(1'b1, FC_READ_HOLDING, 16'h0001, 16'h0000, EXC_NONE, 16'h012C, 1'b0);
		$display("done: bounds and addressing");
		tx(1'b0, FC_READ_INPUT, IR_DRIVE_STATUS, 16'h0000, EXC_NONE, 16'h0000, 1'b0);
		tx(1'b0, 8'h05, 16'h0001, 16'h0000, EXC_BAD_FUNCTION, 16'h0000, 1'b0);
		foreach (modes[i]) begin
			wr(HR_OPERATING_MODE_SELECT, {12'h000, modes[i]}, EXC_NONE);
			@(negedge clk);
			chk(operating_mode, modes[i], "mode");
		end
		wr(HR_OPERATING_MODE_SELECT, 16'h000D, EXC_BAD_VALUE);
		rv = 16'($random(seed));
		wr(HR_TEMPORARY_SETPOINT, rv, EXC_NONE);
		@(negedge clk);
		chk(temp_setpoint, rv, "setpoint");
		rd(HR_TEMPORARY_SETPOINT, 16'h0000);
		rv = 16'($random(seed)) & 16'h7FFF;
		wr(HR_LOOP_GAIN_PROPORTIONAL, rv, EXC_NONE);
		rd(HR_LOOP_GAIN_PROPORTIONAL, rv);
		wr(HR_FAULT_CLEAR_RESTART, 16'h0001, EXC_NONE);
		@(negedge clk);
		chk(fault_clear, 1, "clear pulse");
		rd(HR_FAULT_CLEAR_RESTART, 16'h0000);
		$display("done: functions and special registers");
		tick_gap(rs485_tick, gap);
		chk(gap, 32'(DIV_SLOW), "slow rate");
		tick_gap(service_tick, gap);
		chk(gap, 32'(DIV_SERVICE), "service rate");
		wr(HR_LINE_RATE_SELECT, RATE_CODE_FAST, EXC_NONE);
		tick_gap(rs485_tick, gap);
		chk(gap, 32'(DIV_FAST), "fast rate");
		@(posedge clk);
		measured_speed <= 16'h03E9;
		repeat (3) @(negedge clk);
		chk(carrier_low, 1, "carrier fast");
		@(posedge clk);
		measured_speed <= 16'h03E8;
		repeat (3) @(negedge clk);
		chk(carrier_low, 0, "carrier slow");
		$display("done: rates");
		wr(HR_LINK_LOSS_TIMEOUT, 16'h0002, EXC_NONE);
		repeat (15) @(negedge clk);
		rd(HR_LINK_LOSS_TIMEOUT, 16'h0002);
		repeat (15) @(negedge clk);
		chk(fan_stop, 0, "timer restarted");
		gap = 0;
		while (fan_stop !== 1'b1 && gap < 40) begin
			@(negedge clk);
			gap++;
		end
		chk(fan_stop, 1, "link loss stop");
		wr(HR_FAULT_CLEAR_RESTART, 16'h0001, EXC_NONE);
		wr(HR_LINK_LOSS_TIMEOUT, 16'h0000, EXC_NONE);
		repeat (60) @(negedge clk);
		chk(fan_stop, 0, "timeout off");
		chk(exp_q.size(), 0, "answers left");
		$display("done: link loss");
		summarize();
	end
endmodule
